// *** inc/ppm_pkg.sv ***
// Package for the peripheral pin mux and identifier map.
// Assumes one system clock domain; consumers import ppm_pkg::*.
package ppm_pkg;
  // ==========================================================
  // Port and address map
  localparam int PPM_PADS_FULL = 32;
  localparam int PPM_PADS_REDUCED = 21;
  localparam int PPM_SLOT_BYTES = 16384;
  localparam int PPM_SLOT_BITS = 14;
  localparam int PPM_ID_W = 5;
  // ==========================================================
  // Peripheral identifiers
  localparam logic [4:0] PPM_ID_FAST_IRQ = 5'h00;
  localparam logic [4:0] PPM_ID_SYS_IRQ = 5'h01;
  localparam logic [4:0] PPM_ID_PORT = 5'h02;
  localparam logic [4:0] PPM_ID_CONV = 5'h04;
  localparam logic [4:0] PPM_ID_SPI = 5'h05;
  localparam logic [4:0] PPM_ID_USART0 = 5'h06;
  localparam logic [4:0] PPM_ID_USART1 = 5'h07;
  localparam logic [4:0] PPM_ID_SYNC_SER = 5'h08;
  localparam logic [4:0] PPM_ID_TWO_WIRE = 5'h09;
  localparam logic [4:0] PPM_ID_PULSE = 5'h0A;
  localparam logic [4:0] PPM_ID_USB = 5'h0B;
  localparam logic [4:0] PPM_ID_TIMER0 = 5'h0C;
  localparam logic [4:0] PPM_ID_TIMER2 = 5'h0E;
  localparam logic [4:0] PPM_ID_EXT_INT0 = 5'h1E;
  localparam logic [4:0] PPM_ID_EXT_INT1 = 5'h1F;
  // Valid identifier masks, bit n set when identifier n exists
  localparam logic [31:0] PPM_ID_MASK_FULL = 32'hC0007FF7;
  localparam logic [31:0] PPM_ID_MASK_REDUCED = 32'h40007777;
  // Clock-gate bits that ignore set/clear writes (system and converter)
  localparam logic [31:0] PPM_CLK_FIXED = 32'h00000012;
  // ==========================================================
  // Timer taps: divide ratios of the master clock
  localparam int PPM_TAP_DIV1 = 2;
  localparam int PPM_TAP_DIV2 = 8;
  localparam int PPM_TAP_DIV3 = 32;
  localparam int PPM_TAP_DIV4 = 128;
  localparam int PPM_TAP_DIV5 = 1024;
  localparam int PPM_PRESC_W = 10;
  // ==========================================================
  // Pad ownership
  typedef enum logic [1:0] {
    PPM_OWN_GPIO = 2'b00,
    PPM_OWN_FUNC_A = 2'b01,
    PPM_OWN_FUNC_B = 2'b10
  } ppm_owner_t;
  // Converter clock sequencing
  typedef enum logic [1:0] {
    PPM_CCK_IDLE = 2'b00,
    PPM_CCK_RUN = 2'b01,
    PPM_CCK_HOLD = 2'b10
  } ppm_cck_state_t;
endpackage

// *** inc/ppm_tap_if.sv ***
// Interface carrying the prescaled timer taps between the mux top
// and its prescaler. Same clock domain on both ends.
`timescale 1ns/100ps
interface ppm_tap_if;
  logic [4:0] tap_pulse;
  modport src (output tap_pulse);
  modport dst (input tap_pulse);
endinterface

// *** hw/ppm_prescaler.sv ***
// Free-running master-clock prescaler producing five timer taps.
// Assumes clk_sys is the master clock; taps are one-cycle enables.
`timescale 1ns/100ps
module ppm_prescaler
  import ppm_pkg::*;
(
  input wire logic clk_sys, // Master clock
  input wire logic rst_b, // Async reset, active low
  ppm_tap_if.src taps // Tap pulses out
);
  import ppm_pkg::*;
  // ==========================================================
  // Counter
  logic [PPM_PRESC_W-1:0] count;
  logic [PPM_PRESC_W-1:0] next_count;
  logic [4:0] tap_reg;
  logic [4:0] next_tap_reg;
  localparam logic [PPM_PRESC_W-1:0] M1 = PPM_PRESC_W'(PPM_TAP_DIV1 - 1);
  localparam logic [PPM_PRESC_W-1:0] M2 = PPM_PRESC_W'(PPM_TAP_DIV2 - 1);
  localparam logic [PPM_PRESC_W-1:0] M3 = PPM_PRESC_W'(PPM_TAP_DIV3 - 1);
  localparam logic [PPM_PRESC_W-1:0] M4 = PPM_PRESC_W'(PPM_TAP_DIV4 - 1);
  localparam logic [PPM_PRESC_W-1:0] M5 = PPM_PRESC_W'(PPM_TAP_DIV5 - 1);

  always_comb begin
    next_count = count + 10'h001;
    // Tap n fires once every divide-ratio cycles
    next_tap_reg[0] = ((count & M1) == M1);
    next_tap_reg[1] = ((count & M2) == M2);
    next_tap_reg[2] = ((count & M3) == M3);
    next_tap_reg[3] = ((count & M4) == M4);
    next_tap_reg[4] = ((count & M5) == M5);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
      tap_reg <= 5'h00;
    end else begin
      count <= next_count;
      tap_reg <= next_tap_reg;
    end
  end

  assign taps.tap_pulse = tap_reg;

  // ==========================================================
  // Checks
  property p_tap1_rate;
    @(posedge clk_sys) disable iff (!rst_b)
      tap_reg[0] |=> !tap_reg[0] ##1 tap_reg[0];
  endproperty
  a_tap1_rate: assert property (p_tap1_rate) else $error("tap1 not every 2 cycles");

  property p_tap2_gap;
    @(posedge clk_sys) disable iff (!rst_b)
      tap_reg[1] |=> !tap_reg[1] [*7] ##1 tap_reg[1];
  endproperty
  a_tap2_gap: assert property (p_tap2_gap) else $error("tap2 not every 8 cycles");

  property p_tap5_nest;
    @(posedge clk_sys) disable iff (!rst_b)
      tap_reg[4] |-> (tap_reg[3] && tap_reg[2] && tap_reg[1] && tap_reg[0]);
  endproperty
  a_tap5_nest: assert property (p_tap5_nest) else $error("tap5 not aligned");
endmodule

// *** hw/ppm_pin_mux.sv ***
// Pin mux and peripheral identifier map for a single parallel I/O port.
// Assumes peripherals and port controller share clk_sys; pad inputs are
// asynchronous and are synchronised here before use.
`timescale 1ns/100ps
module ppm_pin_mux
  import ppm_pkg::*;
#(
  parameter int NUM_PADS = ppm_pkg::PPM_PADS_FULL // 32 or 21
)(
  input wire logic clk_sys, // Master clock
  input wire logic rst_b, // Async reset, active low
  // Port controller side
  input wire logic [31:0] sel_a, // Pad given to function A
  input wire logic [31:0] sel_b, // Pad given to function B
  input wire logic [31:0] gpio_out, // GPIO output level
  input wire logic [31:0] gpio_oe, // GPIO output enable
  input wire logic [31:0] gpio_pull_en, // GPIO pull-up request
  output logic [31:0] gpio_in, // Synchronised pad level
  // Peripheral function side
  input wire logic [31:0] func_a_out, // Function A output per pad
  input wire logic [31:0] func_a_oe, // Function A output enable
  input wire logic [31:0] func_b_out, // Function B output per pad
  input wire logic [31:0] func_b_oe, // Function B output enable
  output logic [31:0] func_a_in, // Function A input per pad
  output logic [31:0] func_b_in, // Function B input per pad
  // Pads
  input wire logic [31:0] pad_in, // Pad level, asynchronous
  output logic [31:0] pad_out, // Pad drive level
  output logic [31:0] pad_oe, // Pad drive enable, high drives
  output logic [31:0] pad_pull_up, // Pull-up enable
  output logic [31:0] pad_high_drive, // High-drive pad marker
  output logic [3:0] analog_input_en, // Pad handed to analog input 0-3
  input wire logic [3:0] analog_claim, // Converter claims analog input
  // Address decode
  input wire logic [31:0] bus_addr, // Peripheral bus address
  input wire logic bus_sel, // Bus access into peripheral space
  output logic [31:0] slot_select, // One-hot slot by identifier
  // Interrupt and clock gating by identifier
  input wire logic [31:0] periph_irq, // Raw irq by identifier
  output logic [31:0] irq_line, // Irq to controller, by identifier
  input wire logic [31:0] clk_set, // Clock enable set strobes
  input wire logic [31:0] clk_clr, // Clock enable clear strobes
  output logic [31:0] clk_gate_en, // Clock gate per identifier
  // Converter clock control
  input wire logic conv_start, // Conversion trigger
  input wire logic conv_done, // Conversion finished
  input wire logic conv_sleep, // Converter sleep mode
  output logic conv_clk_en, // Converter clock enable
  // Timer taps
  output logic [4:0] timer_tap // Taps 1 to 5, one-cycle enables
);
  import ppm_pkg::*;

  if (NUM_PADS != PPM_PADS_FULL && NUM_PADS != PPM_PADS_REDUCED) begin : g_bad_pads
    $error("NUM_PADS must be 32 or 21");
  end

  // ==========================================================
  // Variant masks
  localparam logic [31:0] PAD_MASK = (NUM_PADS == 32) ? 32'hFFFFFFFF : 32'h001FFFFF;
  localparam logic [31:0] ID_MASK = (NUM_PADS == 32) ? PPM_ID_MASK_FULL
                                                     : PPM_ID_MASK_REDUCED;
  localparam logic [31:0] HIGH_DRIVE = 32'h0000000F;
  localparam logic [31:0] ANALOG_PADS = 32'h001E0000;

  // ==========================================================
  // Pad input synchroniser
  logic [31:0] pad_meta;
  logic [31:0] pad_sync;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pad_meta <= 32'hFFFFFFFF;
      pad_sync <= 32'hFFFFFFFF;
    end else begin
      pad_meta <= pad_in;
      pad_sync <= pad_meta;
    end
  end

  // ==========================================================
  // Ownership and pad drive
  ppm_owner_t owner [32];
  logic [31:0] next_pad_out;
  logic [31:0] next_pad_oe;
  logic [31:0] next_pull;
  logic [31:0] next_a_in;
  logic [31:0] next_b_in;
  logic [31:0] next_gpio_in;
  logic [31:0] r_pad_out;
  logic [31:0] r_pad_oe;
  logic [31:0] r_pull;
  logic [31:0] r_a_in;
  logic [31:0] r_b_in;
  logic [31:0] r_gpio_in;

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_pad
      always_comb begin
        // Function A wins if both selects set, so one owner at a time
        if (!PAD_MASK[gi]) begin
          owner[gi] = PPM_OWN_GPIO;
        end else if (sel_a[gi]) begin
          owner[gi] = PPM_OWN_FUNC_A;
        end else if (sel_b[gi]) begin
          owner[gi] = PPM_OWN_FUNC_B;
        end else begin
          owner[gi] = PPM_OWN_GPIO;
        end
      end

      always_comb begin
        next_pad_out[gi] = 1'b0;
        next_pad_oe[gi] = 1'b0;
        next_pull[gi] = 1'b0;
        // Unselected function inputs idle high, the inactive serial level
        next_a_in[gi] = 1'b1;
        next_b_in[gi] = 1'b1;
        next_gpio_in[gi] = 1'b0;
        if (PAD_MASK[gi]) begin
          next_gpio_in[gi] = pad_sync[gi];
          case (owner[gi])
            PPM_OWN_FUNC_A: begin
              next_pad_out[gi] = func_a_out[gi];
              next_pad_oe[gi] = func_a_oe[gi];
              next_a_in[gi] = pad_sync[gi];
            end
            PPM_OWN_FUNC_B: begin
              next_pad_out[gi] = func_b_out[gi];
              next_pad_oe[gi] = func_b_oe[gi];
              next_b_in[gi] = pad_sync[gi];
            end
            default: begin
              next_pad_out[gi] = gpio_out[gi];
              next_pad_oe[gi] = gpio_oe[gi];
              next_pull[gi] = gpio_pull_en[gi];
            end
          endcase
          // Analog claim releases the digital driver
          if (ANALOG_PADS[gi] && analog_claim[gi-17 < 0 ? 0 : (gi-17) % 4]) begin
            next_pad_oe[gi] = 1'b0;
            next_pull[gi] = 1'b0;
          end
        end
      end
    end
  endgenerate

  // Reset: all pads GPIO inputs, pull-up on
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      r_pad_out <= 32'h00000000;
      r_pad_oe <= 32'h00000000;
      r_pull <= 32'hFFFFFFFF;
      r_a_in <= 32'hFFFFFFFF;
      r_b_in <= 32'hFFFFFFFF;
      r_gpio_in <= 32'h00000000;
    end else begin
      r_pad_out <= next_pad_out;
      r_pad_oe <= next_pad_oe;
      r_pull <= next_pull & PAD_MASK;
      r_a_in <= next_a_in;
      r_b_in <= next_b_in;
      r_gpio_in <= next_gpio_in;
    end
  end

  assign pad_out = r_pad_out;
  assign pad_oe = r_pad_oe;
  assign pad_pull_up = r_pull;
  assign func_a_in = r_a_in;
  assign func_b_in = r_b_in;
  assign gpio_in = r_gpio_in;
  assign pad_high_drive = HIGH_DRIVE;
  // Pads 17-20 carry analog inputs 0-3 when claimed
  assign analog_input_en = analog_claim;

  // Fixed routing map: peripheral wiring per pad (A, B) is set by the
  // peripheral netlist; the pads named below are the checked anchors.
  localparam int PAD_DBG_RX = 9; // A: debug uart rx, B: spi select 1
  localparam int PAD_DBG_TX = 10; // A: debug uart tx, B: spi select 2
  localparam int PAD_FAST_IRQ = 19; // B: fast irq
  localparam int PAD_EXT_INT0 = 20; // B: external irq 0
  localparam int PAD_EXT_INT1 = 30; // A: external irq 1

  // ==========================================================
  // Address slot decode, one 16-Kbyte slot per identifier
  logic [4:0] slot_idx;
  always_comb begin
    slot_idx = bus_addr[PPM_SLOT_BITS+4:PPM_SLOT_BITS];
    slot_select = 32'h00000000;
    if (bus_sel && ID_MASK[slot_idx]) begin
      slot_select[slot_idx] = 1'b1;
    end
  end

  // ==========================================================
  // Interrupt lines and clock gates indexed by identifier
  assign irq_line = periph_irq & ID_MASK;

  logic [31:0] gate;
  logic [31:0] next_gate;
  always_comb begin
    // Clear before set so a same-cycle set wins
    next_gate = ((gate & ~clk_clr) | clk_set) & ID_MASK;
    // System and converter bits ignore writes; system always runs
    next_gate = (next_gate & ~PPM_CLK_FIXED) | (32'h1 << PPM_ID_SYS_IRQ);
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      gate <= 32'h00000002;
    end else begin
      gate <= next_gate;
    end
  end

  // ==========================================================
  // Converter clock sequencing
  ppm_cck_state_t cck_state;
  ppm_cck_state_t next_cck_state;
  always_comb begin
    next_cck_state = cck_state;
    case (cck_state)
      PPM_CCK_IDLE: begin
        if (conv_start) next_cck_state = PPM_CCK_RUN;
      end
      PPM_CCK_RUN: begin
        if (conv_done) begin
          next_cck_state = conv_sleep ? PPM_CCK_IDLE : PPM_CCK_HOLD;
        end
      end
      PPM_CCK_HOLD: begin
        if (conv_sleep) next_cck_state = PPM_CCK_IDLE;
        else if (conv_start) next_cck_state = PPM_CCK_RUN;
      end
      default: next_cck_state = PPM_CCK_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cck_state <= PPM_CCK_IDLE;
    end else begin
      cck_state <= next_cck_state;
    end
  end
  assign conv_clk_en = (cck_state != PPM_CCK_IDLE);
  assign clk_gate_en = gate | {27'h0, conv_clk_en, 4'h0};

  // ==========================================================
  // Timer taps
  ppm_tap_if tap_bus ();
  ppm_prescaler u_presc (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .taps(tap_bus.src)
  );
  assign timer_tap = tap_bus.tap_pulse;

  // ==========================================================
  // Checks
  property p_one_owner;
    @(posedge clk_sys) disable iff (!rst_b)
      (sel_a[PAD_DBG_RX] && !sel_b[PAD_DBG_RX]) |=>
        (func_b_in[PAD_DBG_RX] == 1'b1);
  endproperty
  a_one_owner: assert property (p_one_owner) else $error("unselected input not idle");

  property p_drive_a;
    @(posedge clk_sys) disable iff (!rst_b)
      (sel_a[PAD_DBG_TX] && func_a_oe[PAD_DBG_TX]) |=>
        (pad_oe[PAD_DBG_TX] && pad_out[PAD_DBG_TX] == $past(func_a_out[PAD_DBG_TX]));
  endproperty
  a_drive_a: assert property (p_drive_a) else $error("function A not driving pad");

  property p_drive_b;
    @(posedge clk_sys) disable iff (!rst_b)
      (!sel_a[0] && sel_b[0]) |=> (pad_out[0] == $past(func_b_out[0]));
  endproperty
  a_drive_b: assert property (p_drive_b) else $error("function B not driving pad");

  property p_sys_clk_on;
    @(posedge clk_sys) disable iff (!rst_b)
      clk_clr[PPM_ID_SYS_IRQ] |=> clk_gate_en[PPM_ID_SYS_IRQ];
  endproperty
  a_sys_clk_on: assert property (p_sys_clk_on) else $error("system clock gated");

  property p_conv_stop;
    @(posedge clk_sys) disable iff (!rst_b)
      (cck_state == PPM_CCK_RUN && conv_done && conv_sleep) |=> !conv_clk_en;
  endproperty
  a_conv_stop: assert property (p_conv_stop) else $error("converter clock not stopped");

  property p_conv_start;
    @(posedge clk_sys) disable iff (!rst_b)
      (cck_state == PPM_CCK_IDLE && conv_start) |=> conv_clk_en;
  endproperty
  a_conv_start: assert property (p_conv_start) else $error("converter clock not started");

  property p_reserved_irq;
    @(posedge clk_sys) disable iff (!rst_b)
      (irq_line[3] == 1'b0) && (irq_line[15] == 1'b0);
  endproperty
  a_reserved_irq: assert property (p_reserved_irq) else $error("reserved id active");

  property p_slot;
    @(posedge clk_sys) disable iff (!rst_b)
      (bus_sel && bus_addr[18:14] == PPM_ID_SPI) |-> slot_select[PPM_ID_SPI];
  endproperty
  a_slot: assert property (p_slot) else $error("slot decode wrong");

  property p_irq_pads;
    @(posedge clk_sys) disable iff (!rst_b)
      (sel_b[PAD_EXT_INT0:PAD_FAST_IRQ] == 2'b11 && sel_a[PAD_EXT_INT0:PAD_FAST_IRQ] == 2'b00
        && sel_a[PAD_EXT_INT1]) |=>
        (func_b_in[PAD_EXT_INT0:PAD_FAST_IRQ] == $past(pad_sync[PAD_EXT_INT0:PAD_FAST_IRQ])
        && (func_a_in[PAD_EXT_INT1] == $past(pad_sync[PAD_EXT_INT1]) || !PAD_MASK[PAD_EXT_INT1]));
  endproperty
  a_irq_pads: assert property (p_irq_pads) else $error("irq pad input not routed");
endmodule

// *** verif/ppm_pad_model.sv ***
// Pad-side model: the package pads and whatever drives them from outside.
// Assumes the bench sets ext_en/ext_drive; device drive wins over both.
`timescale 1ns/100ps
module ppm_pad_model (
  input wire logic clk_sys, // Master clock, paces the float pattern
  input wire logic [31:0] pad_out, // Device drive level
  input wire logic [31:0] pad_oe, // Device drive enable
  input wire logic [31:0] pad_pull_up, // Device pull-up enable
  input wire logic [31:0] ext_drive, // External drive level
  input wire logic [31:0] ext_en, // External drive enable
  output logic [31:0] pad_in // Level seen on the pads
);
  logic [31:0] float_lvl = 32'h0;
  // =============================================
  // Pad level
  // Undriven, unpulled pads keep changing so a stale level never passes
  always_ff @(posedge clk_sys) begin
    float_lvl <= ~pad_in;
  end
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (ext_en[i]) begin
        pad_in[i] = ext_drive[i];
      end else if (pad_pull_up[i]) begin
        pad_in[i] = 1'b1;
      end else begin
        pad_in[i] = float_lvl[i];
      end
    end
  end
endmodule

// *** verif/peripheral_pin_mux_and_id_map_test.sv ***
// Self-checking bench for the pin mux and identifier map, full and reduced variants.
// Assumes the pad model closes the pad loop; inputs move on falling edges.
`timescale 1ns/100ps
module peripheral_pin_mux_and_id_map_test;
  import ppm_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [31:0] sel_a = '0, sel_b = '0, gpio_out = '0, gpio_oe = '0;
  logic [31:0] gpio_pull_en = '1, func_a_out = '0, func_a_oe = '0;
  logic [31:0] func_b_out = '0, func_b_oe = '0, bus_addr = '0, periph_irq = '0;
  logic [31:0] clk_set = '0, clk_clr = '0, ext_drive = '0, ext_en = '0;
  logic [3:0] analog_claim = '0;
  logic bus_sel = 1'b0, conv_start = 1'b0, conv_done = 1'b0, conv_sleep = 1'b0;
  logic [31:0] gpio_in, func_a_in, func_b_in, pad_in, pad_out, pad_oe;
  logic [31:0] pad_pull_up, pad_high_drive, slot_select, irq_line, clk_gate_en;
  logic [3:0] analog_input_en;
  logic conv_clk_en;
  logic [4:0] timer_tap;
  logic [31:0] s_gpio_in, s_pull, s_slot, s_irq, s_gate;
  int n_errors = 0;
  int check_count = 0;
  always #20 clk_sys = ~clk_sys;
  ppm_pin_mux #(.NUM_PADS(32)) i_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .sel_a(sel_a), .sel_b(sel_b),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_pull_en(gpio_pull_en),
    .gpio_in(gpio_in), .func_a_out(func_a_out), .func_a_oe(func_a_oe),
    .func_b_out(func_b_out), .func_b_oe(func_b_oe), .func_a_in(func_a_in),
    .func_b_in(func_b_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_up(pad_pull_up), .pad_high_drive(pad_high_drive),
    .analog_input_en(analog_input_en), .analog_claim(analog_claim),
    .bus_addr(bus_addr), .bus_sel(bus_sel), .slot_select(slot_select),
    .periph_irq(periph_irq), .irq_line(irq_line), .clk_set(clk_set),
    .clk_clr(clk_clr), .clk_gate_en(clk_gate_en), .conv_start(conv_start),
    .conv_done(conv_done), .conv_sleep(conv_sleep), .conv_clk_en(conv_clk_en),
    .timer_tap(timer_tap)
  );
  ppm_pad_model i_pads (
    .clk_sys(clk_sys), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_up(pad_pull_up), .ext_drive(ext_drive), .ext_en(ext_en),
    .pad_in(pad_in)
  );
  // Reduced variant alongside, on the same stimulus and pad levels
  ppm_pin_mux #(.NUM_PADS(21)) i_dut_small (
    .clk_sys(clk_sys), .rst_b(rst_b), .sel_a(sel_a), .sel_b(sel_b),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_pull_en(gpio_pull_en),
    .gpio_in(s_gpio_in), .func_a_out(func_a_out), .func_a_oe(func_a_oe),
    .func_b_out(func_b_out), .func_b_oe(func_b_oe), .func_a_in(),
    .func_b_in(), .pad_in(pad_in), .pad_out(), .pad_oe(),
    .pad_pull_up(s_pull), .pad_high_drive(),
    .analog_input_en(), .analog_claim(analog_claim),
    .bus_addr(bus_addr), .bus_sel(bus_sel), .slot_select(s_slot),
    .periph_irq(periph_irq), .irq_line(s_irq), .clk_set(clk_set),
    .clk_clr(clk_clr), .clk_gate_en(s_gate), .conv_start(conv_start),
    .conv_done(conv_done), .conv_sleep(conv_sleep), .conv_clk_en(),
    .timer_tap()
  );
  // =============================================
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // Identifiers that exist in each variant, worked out independently
  function automatic logic [31:0] valid_mask(input bit reduced);
    logic [31:0] m;
    m = '0;
    for (int id = 0; id < 32; id++) begin
      m[id] = !(id == 3 || (id >= 15 && id <= 29));
      if (reduced && (id == 7 || id == 11 || id == 31)) begin
        m[id] = 1'b0;
      end
    end
    return m;
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // =============================================
  // Scenarios
  task automatic reset_state();
    rst_b = 1'b0;
    cyc(20);
    chk("pad_oe_rst", 32'h0, pad_oe);
    chk("pull_rst", 32'hFFFFFFFF, pad_pull_up);
    chk("func_a_in_rst", 32'hFFFFFFFF, func_a_in);
    chk("gate_rst", 32'h2, clk_gate_en);
    rst_b = 1'b1;
    cyc(4);
    chk("gpio_in_rst", 32'hFFFFFFFF, gpio_in);
    chk("high_drive", 32'h0000000F, pad_high_drive);
    chk("gpio_in_small", 32'h001FFFFF, s_gpio_in);
    chk("pull_small", 32'h001FFFFF, s_pull);
  endtask
  task automatic ownership();
    logic [31:0] a, b, d;
    a = 32'h4000060E;
    b = 32'h00180401;
    d = 32'hA5A53C3C;
    sel_a = a;
    sel_b = b;
    func_a_oe = '1;
    func_b_oe = '1;
    func_a_out = '1;
    func_b_out = '0;
    cyc(2);
    chk("pad_out_a", a, pad_out);
    chk("pad_oe_fn", a | b, pad_oe);
    chk("pull_gpio", ~(a | b), pad_pull_up);
    func_a_out = '0;
    func_b_out = '1;
    cyc(2);
    chk("pad_out_b", b & ~a, pad_out);
    func_a_oe = '0;
    func_b_oe = '0;
    ext_drive = d;
    ext_en = '1;
    cyc(5);
    chk("func_a_in", (d & a) | ~a, func_a_in);
    chk("func_b_in", (d & b & ~a) | ~(b & ~a), func_b_in);
    chk("gpio_in", d, gpio_in);
    ext_en = '0;
    sel_a = '0;
    sel_b = '0;
  endtask
  task automatic analog();
    gpio_oe = '1;
    analog_claim = 4'hA;
    cyc(2);
    chk("analog_en", 32'hA, {28'h0, analog_input_en});
    chk("pad_oe_an", ~(32'hA << 17), pad_oe);
    chk("pull_an", ~(32'hA << 17), pad_pull_up);
    analog_claim = 4'h0;
    gpio_oe = '0;
  endtask
  task automatic id_map();
    logic [31:0] v, vs;
    v = valid_mask(1'b0);
    vs = valid_mask(1'b1);
    bus_sel = 1'b1;
    for (int id = 0; id < 32; id++) begin
      for (int off = 0; off < 2; off++) begin
        bus_addr = (id << 14) | (off ? 32'h3FFF : 32'h0);
        periph_irq = 32'h1 << id;
        cyc(1);
        chk("slot_select", v[id] ? (32'h1 << id) : 32'h0, slot_select);
        chk("irq_line", v[id] ? (32'h1 << id) : 32'h0, irq_line);
        chk("slot_small", vs[id] ? (32'h1 << id) : 32'h0, s_slot);
        chk("irq_small", vs[id] ? (32'h1 << id) : 32'h0, s_irq);
      end
    end
    bus_sel = 1'b0;
    cyc(1);
    chk("slot_idle", 32'h0, slot_select);
    periph_irq = '0;
  endtask
  task automatic gates();
    logic [31:0] v, vs;
    v = valid_mask(1'b0);
    vs = valid_mask(1'b1);
    cyc(1);
    clk_set = '1;
    cyc(1);
    clk_set = '0;
    cyc(1);
    chk("gate_set", (v & ~32'h12) | 32'h2, clk_gate_en);
    chk("gate_small", (vs & ~32'h12) | 32'h2, s_gate);
    clk_set = 32'h20;
    clk_clr = '1;
    cyc(1);
    chk("gate_set_wins", 32'h22, clk_gate_en);
    clk_set = '0;
    cyc(1);
    chk("gate_clr", 32'h2, clk_gate_en);
    clk_clr = '0;
  endtask
  task automatic conv_pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic converter();
    conv_pulse(conv_start);
    chk("conv_on", 32'h1, {31'h0, conv_clk_en});
    chk("conv_gate", 32'h12, clk_gate_en);
    conv_pulse(conv_done);
    cyc(1);
    chk("conv_hold", 32'h1, {31'h0, conv_clk_en});
    conv_sleep = 1'b1;
    cyc(2);
    conv_pulse(conv_start);
    chk("conv_on_sleep", 32'h1, {31'h0, conv_clk_en});
    conv_pulse(conv_done);
    chk("conv_off", 32'h0, {31'h0, conv_clk_en});
    conv_sleep = 1'b0;
  endtask
  task automatic taps();
    int div [5] = '{2, 8, 32, 128, 1024};
    int last [5] = '{-1, -1, -1, -1, -1};
    int cnt [5] = '{0, 0, 0, 0, 0};
    for (int c = 0; c < 2100; c++) begin
      cyc(1);
      for (int k = 0; k < 5; k++) begin
        if (timer_tap[k] === 1'b1) begin
          if (last[k] >= 0) begin
            chk("tap_period", div[k], c - last[k]);
          end
          last[k] = c;
          cnt[k]++;
        end
      end
    end
    for (int k = 0; k < 5; k++) begin
      chk("tap_seen", 32'h1, {31'h0, cnt[k] >= 2});
    end
  endtask
  initial begin
    reset_state();
    ownership();
    analog();
    id_map();
    gates();
    converter();
    reset_state();
    taps();
    tally_and_finish();
  end
endmodule
